// ### include/event_counter_map.vh
// Register offsets, field positions, reset values and mode codes of the event counter
`ifndef EVENT_COUNTER_MAP_VH
`define EVENT_COUNTER_MAP_VH
`define OFS_MODE 5'h00
`define OFS_TIMER 5'h04
`define OFS_CONTROL 5'h08
`define OFS_STATUS 5'h0C
`define OFS_MASK 5'h10
`define CONTROL_START 0
`define STATUS_UNDERFLOW 0
`define MASK_UNDERFLOW 0
`define OP_MODE_LSB 0
`define OP_MODE_MSB 1
`define EDGE_POL_LSB 2
`define EDGE_POL_MSB 3
`define MODE_BIT5 5
`define EVENT_CLOCK_SEL 7
`define OP_MODE_EVENT 2'h1
`define POL_FALL 2'h0
`define POL_RISE 2'h1
`define POL_BOTH 2'h2
`define MODE_RESET 8'h00
`define TIMER_RESET 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### rtl/event_counter.v
// Event counter mode of a 16-bit down counter with reload, behind an AXI4-Lite slave
// Overview of operation
// - Event mode counts edges from input pin
// - Decrement per edge; reload on underflow
// - Reload n gives one underflow per n+1
// - Start flag one starts counting
// - Start flag zero holds counter value
// - Interrupt request on every underflow; here IRQ is status & mask, so only while the mask bit is set
// - Timer read returns live counter value
// - Stopped write loads reload and counter
// - Running write loads reload only
// - Mode field 01 selects event counting
// - Polarity: 00 fall, 01 rise, 10 both
// - Mode bit 5 written zero, reads undefined
// - Bit 7 selects pin or sibling overflow
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "event_counter_map.vh"
module event_counter #(
	parameter WIDTH = 16
) (
	input wire CLK,
	input wire RESET_N,
	input wire [4:0] AWADDR,
	input wire AWVALID,
	output wire AWREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output wire WREADY,
	output reg [1:0] BRESP,
	output reg BVALID,
	input wire BREADY,
	input wire [4:0] ARADDR,
	input wire ARVALID,
	output wire ARREADY,
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	output reg RVALID,
	input wire RREADY,
	input wire EVENT_INPUT_PIN,
	input wire SIBLING_OVERFLOW,
	output reg UNDERFLOW,
	output wire IRQ
);
	localparam NUM_SRC = 2;
	localparam SRC_PIN = 0;
	localparam SRC_SIB = 1;
	localparam LANE_LO = 0;
	localparam LANE_HI = 1;
	reg [7:0] mode;
	reg [WIDTH-1:0] counter;
	reg [WIDTH-1:0] reload;
	reg count_start;
	reg status;
	reg mask;
	reg armed;
	reg aw_held;
	reg w_held;
	reg [4:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg [7:0] next_mode;
	reg [WIDTH-1:0] next_counter;
	reg [WIDTH-1:0] next_reload;
	reg next_count_start;
	reg next_status;
	reg next_mask;
	reg next_underflow;
	reg [1:0] next_bresp;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;
	reg pin_edge;
	wire [NUM_SRC-1:0] src_level;
	wire [NUM_SRC-1:0] src_rise;
	wire [NUM_SRC-1:0] src_fall;
	wire [1:0] op_mode_sel = mode[`OP_MODE_MSB:`OP_MODE_LSB];
	wire [1:0] edge_polarity = mode[`EDGE_POL_MSB:`EDGE_POL_LSB];
	wire event_clock_select = mode[`EVENT_CLOCK_SEL];
	wire event_mode = (op_mode_sel == `OP_MODE_EVENT);
	wire sib_edge = src_rise[SRC_SIB];
	wire effective_edge = event_clock_select ? sib_edge : pin_edge;
	wire counting = event_mode & count_start;
	wire tick = counting & effective_edge;
	wire underflow_now = tick & (counter == {WIDTH{1'b0}});
	wire do_write = aw_held & w_held & ~BVALID;
	wire hit_mode = (aw_addr == `OFS_MODE);
	wire hit_timer = (aw_addr == `OFS_TIMER);
	wire hit_control = (aw_addr == `OFS_CONTROL);
	wire hit_status = (aw_addr == `OFS_STATUS);
	wire hit_mask = (aw_addr == `OFS_MASK);
	wire hit_any = hit_mode | hit_timer | hit_control | hit_status | hit_mask;
	wire wr_mode = do_write & hit_mode;
	wire wr_timer = do_write & hit_timer;
	wire wr_control = do_write & hit_control;
	wire wr_status = do_write & hit_status;
	wire wr_mask = do_write & hit_mask;
	wire [31:0] mode_word = {24'h000000, mode};
	wire [31:0] timer_word = {{(32-WIDTH){1'b0}}, counter};
	wire [31:0] control_word = {31'h00000000, count_start};
	wire [31:0] status_word = {31'h00000000, status};
	wire [31:0] mask_word = {31'h00000000, mask};
	wire [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};
	// Readies are combinational so a free slot is taken in the cycle it is offered
	assign AWREADY = ~aw_held;
	assign WREADY = ~w_held;
	assign ARREADY = ~RVALID;
	assign IRQ = status & mask;
	assign src_level = {SIBLING_OVERFLOW, EVENT_INPUT_PIN};
	// Edge history is not a real level until one clock after reset, so nothing counts before then
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g = g + 1) begin : edge_detect
			reg prev;
			always @(posedge CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					prev <= 1'b0;
				end else begin
					prev <= src_level[g];
				end
			end
			assign src_rise[g] = armed & src_level[g] & ~prev;
			assign src_fall[g] = armed & ~src_level[g] & prev;
		end
	endgenerate
	// Polarity 11 is stored as written; it selects no pin edge rather than guess
	always @* begin
		case (edge_polarity)
		`POL_FALL: begin
			pin_edge = src_fall[SRC_PIN];
		end
		`POL_RISE: begin
			pin_edge = src_rise[SRC_PIN];
		end
		`POL_BOTH: begin
			pin_edge = src_rise[SRC_PIN] | src_fall[SRC_PIN];
		end
		default: begin
			pin_edge = 1'b0;
		end
		endcase
	end
	// Address and data are taken in either order; each slot frees when the write is done
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_held <= 1'b0;
			aw_addr <= 5'h00;
		end else if (AWVALID && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= AWADDR;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (WVALID && !w_held) begin
			w_held <= 1'b1;
			w_data <= WDATA;
			w_strb <= WSTRB;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end
	// Unmapped or unaligned writes get an error response and change nothing
	always @* begin
		if (hit_any) begin
			next_bresp = `RESP_OKAY;
		end else begin
			next_bresp = `RESP_SLVERR;
		end
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
		end else if (do_write) begin
			BVALID <= 1'b1;
			BRESP <= next_bresp;
		end else if (BVALID && BREADY) begin
			BVALID <= 1'b0;
		end
	end
	// Bit 5 has no function here, so it is stored as zero
	always @* begin
		next_mode = mode;
		if (wr_mode && w_strb[LANE_LO]) begin
			next_mode = {w_data[7:6], 1'b0, w_data[4:0]};
		end
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mode <= `MODE_RESET;
		end else begin
			mode <= next_mode;
		end
	end
	always @* begin
		next_count_start = count_start;
		if (wr_control && w_strb[LANE_LO]) begin
			next_count_start = w_data[`CONTROL_START];
		end
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			count_start <= 1'b0;
		end else begin
			count_start <= next_count_start;
		end
	end
	always @* begin
		next_mask = mask;
		if (wr_mask && w_strb[LANE_LO]) begin
			next_mask = w_data[`MASK_UNDERFLOW];
		end
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mask <= 1'b0;
		end else begin
			mask <= next_mask;
		end
	end
	// Every timer write reaches the reload; byte lanes let software load half a word
	always @* begin
		next_reload = reload;
		if (wr_timer) begin
			if (w_strb[LANE_LO]) begin
				next_reload[7:0] = w_data[7:0];
			end
			if (w_strb[LANE_HI]) begin
				next_reload[WIDTH-1:8] = w_data[WIDTH-1:8];
			end
		end
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			reload <= `TIMER_RESET;
		end else begin
			reload <= next_reload;
		end
	end
	// A stopped write also lands in the counter; a running one waits for the next reload
	always @* begin
		next_counter = counter;
		if (underflow_now) begin
			next_counter = reload;
		end else if (tick) begin
			next_counter = counter - one;
		end else if (wr_timer && !counting) begin
			if (w_strb[LANE_LO]) begin
				next_counter[7:0] = w_data[7:0];
			end
			if (w_strb[LANE_HI]) begin
				next_counter[WIDTH-1:8] = w_data[WIDTH-1:8];
			end
		end
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			counter <= `TIMER_RESET;
		end else begin
			counter <= next_counter;
		end
	end
	// Set wins over a same-cycle write-one clear, so no underflow is lost
	always @* begin
		next_status = status;
		if (underflow_now) begin
			next_status = 1'b1;
		end else if (wr_status && w_strb[LANE_LO] && w_data[`STATUS_UNDERFLOW]) begin
			next_status = 1'b0;
		end
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			status <= 1'b0;
		end else begin
			status <= next_status;
		end
	end
	always @* begin
		next_underflow = underflow_now;
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			UNDERFLOW <= 1'b0;
		end else begin
			UNDERFLOW <= next_underflow;
		end
	end
	// Read data are captured when the address is taken and stand until RREADY
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `RESP_OKAY;
		case (ARADDR)
		`OFS_MODE: begin
			next_rdata = mode_word;
		end
		`OFS_TIMER: begin
			next_rdata = timer_word;
		end
		`OFS_CONTROL: begin
			next_rdata = control_word;
		end
		`OFS_STATUS: begin
			next_rdata = status_word;
		end
		`OFS_MASK: begin
			next_rdata = mask_word;
		end
		default: begin
			next_rresp = `RESP_SLVERR;
		end
		endcase
	end
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `RESP_OKAY;
		end else if (ARVALID && !RVALID) begin
			RVALID <= 1'b1;
			RDATA <= next_rdata;
			RRESP <= next_rresp;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end
endmodule

// ### tb/event_counter_sva.sv
// Port checker of the event counter
`timescale 1ns/100ps
module event_counter_sva(input wire CLK, RESET_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, UNDERFLOW,
	input wire ARVALID, ARREADY, RVALID, RREADY, IRQ, input wire [31:0] RDATA);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read dropped");
	a_b_hold: assert property (BVALID && !BREADY |=> BVALID) else $error("bvalid dropped");
	a_r_end: assert property (RVALID && RREADY |=> !RVALID) else $error("rvalid stuck");
	a_b_end: assert property (BVALID && BREADY |=> !BVALID) else $error("bvalid stuck");
	a_ar_gate: assert property (ARREADY != RVALID) else $error("arready wrong");
	a_r_ans: assert property (ARVALID && ARREADY |=> RVALID) else $error("no read answer");
	a_w_ans: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID) else $error("no bvalid");
	a_irq_off: assert property (!$past(RESET_N) |-> !IRQ) else $error("irq after reset");
	c_irq: cover property (IRQ);
	c_rd: cover property (RVALID && RREADY);
	c_wr: cover property (BVALID && BREADY);
	c_ufl: cover property (UNDERFLOW);
endmodule
bind event_counter event_counter_sva i_sva(.*);

// ### tb/edge_src.sv
// Edge source for the event pin and the sibling overflow
`timescale 1ns/100ps
module edge_src(input wire clk, output reg pin = 1'h0, output reg sib = 1'h0);
	// Three cycles per level, so the edge sampler never misses one
	task go(input int n, input bit s = 1'h0);
		repeat (n) begin
			if (s) sib <= ~sib;
			else pin <= ~pin;
			repeat (3) @(posedge clk);
		end
	endtask
endmodule

// ### tb/event_counter_test.sv
// Test bench of the event counter
`timescale 1ns/100ps
module event_counter_test;
	logic CLK = 1'h0, RESET_N = 1'h0, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
	logic [4:0] AWADDR = 5'h0, ARADDR = 5'h0;
	logic [31:0] WDATA = 32'h0;
	logic [3:0] WSTRB = 4'hF;
	wire AWREADY, WREADY, BVALID, ARREADY, RVALID, UNDERFLOW, IRQ, EVENT_INPUT_PIN, SIBLING_OVERFLOW;
	wire [1:0] BRESP, RRESP;
	wire [31:0] RDATA;
	int fails = 0, num_checks = 0;
	int ufl_seen = 0;
	event_counter i_event_counter(.*);
	edge_src i_edge_src(.clk(CLK), .pin(EVENT_INPUT_PIN), .sib(SIBLING_OVERFLOW));
	always #10 CLK = ~CLK;
	always @(posedge CLK) begin
		if (UNDERFLOW === 1'h1)
			ufl_seen <= ufl_seen + 1;
	end
	task ck(input string n, input [33:0] g, e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input [4:0] a, input [31:0] v, input [3:0] s = 4'hF, input [1:0] r = 2'h0);
		@(posedge CLK);
		{AWADDR, WDATA, WSTRB, AWVALID, WVALID, BREADY} <= {a, v, s, 3'h7};
		fork
			begin @(negedge CLK); while (!AWREADY) @(negedge CLK); @(posedge CLK); AWVALID <= 1'h0; end
			begin @(negedge CLK); while (!WREADY) @(negedge CLK); @(posedge CLK); WVALID <= 1'h0; end
		join
		@(negedge CLK);
		while (!BVALID) @(negedge CLK);
		ck("bresp", 34'(BRESP), 34'(r));
		@(posedge CLK);
		BREADY <= 1'h0;
		@(negedge CLK);
	endtask
	task rc(input [4:0] a, input [31:0] e, input [1:0] s = 2'h0);
		@(posedge CLK);
		{ARADDR, ARVALID, RREADY} <= {a, 2'h3};
		@(negedge CLK);
		while (!ARREADY) @(negedge CLK);
		@(posedge CLK);
		ARVALID <= 1'h0;
		@(negedge CLK);
		while (!RVALID) @(negedge CLK);
		ck("read", {RRESP, RDATA}, {s, e});
		@(posedge CLK);
		RREADY <= 1'h0;
		@(negedge CLK);
	endtask
	task t_count;
		wr(5'h0, 32'h5);
		rc(5'h0, 32'h5);
		wr(5'h10, 32'h1);
		wr(5'h4, 32'h2);
		wr(5'h8, 32'h1);
		i_edge_src.go(4);
		rc(5'h4, 32'h0);
		i_edge_src.go(2);
		rc(5'h4, 32'h2);
		ck("underflow", 34'(ufl_seen), 34'h1);
		ck("irq", 34'(IRQ), 34'h1);
		wr(5'h10, 32'h0);
		ck("irq", 34'(IRQ), 34'h0);
		wr(5'hC, 32'h1);
		wr(5'h10, 32'h1);
		ck("irq", 34'(IRQ), 34'h0);
	endtask
	task t_run;
		wr(5'h4, 32'h5);
		i_edge_src.go(2);
		rc(5'h4, 32'h1);
		i_edge_src.go(4);
		rc(5'h4, 32'h5);
		ck("underflow", 34'(ufl_seen), 34'h2);
		wr(5'h8, 32'h0);
		i_edge_src.go(2);
		rc(5'h4, 32'h5);
	endtask
	task t_pol;
		for (int p = 0; p < 3; p++) begin
			wr(5'h4, 32'hA);
			wr(5'h0, {28'h0, p[1:0], 2'h1});
			wr(5'h8, 32'h1);
			i_edge_src.go(4);
			rc(5'h4, p == 2 ? 32'h6 : 32'h8);
			wr(5'h8, 32'h0);
		end
	endtask
	task t_sib;
		wr(5'h4, 32'hA);
		wr(5'h0, 32'h81);
		wr(5'h8, 32'h1);
		i_edge_src.go(6, 1'h1);
		i_edge_src.go(2);
		rc(5'h4, 32'h7);
		rc(5'h14, 32'h0, 2'h2);
		wr(5'h14, 32'h1, 4'hF, 2'h2);
		wr(5'h8, 32'h0);
		wr(5'h4, 32'h0000AB12, 4'h2);
		rc(5'h4, 32'hAB07);
	endtask
	task t_reset;
		ck("irq", 34'(IRQ), 34'h1);
		@(posedge CLK);
		RESET_N <= 1'h0;
		repeat (2) @(posedge CLK);
		RESET_N <= 1'h1;
		@(negedge CLK);
		ck("irq", 34'(IRQ), 34'h0);
		rc(5'h4, 32'h0);
		rc(5'h0, 32'h0);
	endtask
	task results;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge CLK);
		RESET_N <= 1'h1;
		@(posedge CLK);
		t_count;
		t_run;
		t_pol;
		t_sib;
		t_reset;
		results;
	end
	initial begin
		repeat (5000) @(posedge CLK);
		fails++;
		results;
	end
endmodule
